// [hdl/udp_sample_packetizer.sv]
// How it works
// - Emit only the selected value set
// - All values snapshot on one tick
// - Rate is max rate over 2^n, n<=20
// - Max rate reported, capped 1.25 MHz
// - Rate readback gives stored exponent n
// - Format: float32 four bytes, int16 two
// - Int16 saturates; 31000 means full scale
// - Packet data 1024/512/256/128 bytes by code
// - Payload is data plus header bytes
// - No resend; stream never waits receiver
// - Destination port 1024..65535, default 1865
// - Bit0 little-endian, bit1 integrity, default 2
// - Destination IP from enabling host
// - Settings latched only at stream start
`timescale 1ns/1ps
`include "packetizer_map.svh"

// ----------------------------------------
// Shift FIFO, head always in a flop
// ----------------------------------------
module sample_fifo #(
  parameter int W = 9,
  parameter int D = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int CW = $clog2(D + 1);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [CW-1:0] cnt;
    logic vld;
    logic rdy;
  } fifo_s;

  fifo_s f_r;
  fifo_s f_nxt;

  // Pop shifts down, push lands at the new tail
  always_comb begin
    logic [CW-1:0] c;
    c = f_r.cnt;
    f_nxt = f_r;
    if (f_r.vld && out_ready) begin
      for (int i = 0; i < D - 1; i++) begin
        f_nxt.mem[i] = f_r.mem[i+1];
      end
      c = c - CW'(1);
    end
    if (in_valid && f_r.rdy) begin
      f_nxt.mem[c] = in_data;
      c = c + CW'(1);
    end
    f_nxt.cnt = c;
    f_nxt.vld = (c != '0);
    f_nxt.rdy = (c != CW'(D));
  end

  // Registered flags keep full and empty honest
  always_ff @(posedge clk) begin
    if (rst) begin
      f_r <= '0;
      f_r.rdy <= 1'b1;
    end else begin
      f_r <= f_nxt;
    end
  end

  assign in_ready = f_r.rdy;
  assign out_valid = f_r.vld;
  assign out_data = f_r.mem[0];
endmodule

// ----------------------------------------
// Packetizer top
// ----------------------------------------
module udp_sample_packetizer
  import packetizer_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata,
  // Command source
  input wire logic [31:0] cmd_src_ip,
  // Demodulator outputs
  input wire logic base_tick,
  input wire logic [20:0] max_rate_hz,
  input wire logic [31:0] x_f,
  input wire logic [31:0] y_f,
  input wire logic [31:0] r_f,
  input wire logic [31:0] t_f,
  input wire logic signed [31:0] x_q,
  input wire logic signed [31:0] y_q,
  input wire logic signed [31:0] r_q,
  input wire logic signed [31:0] t_q,
  // Datagram byte stream
  output logic [7:0] tx_data,
  output logic tx_last,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [31:0] tx_dst_ip,
  output logic [15:0] tx_dst_port,
  output logic stream_active
);

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------

  // Divider terminal count for exponent n
  function automatic logic [19:0] div_last(input logic [4:0] n);
    logic [20:0] t;
    t = (21'h1 << n) - 21'h1;
    return t[19:0];
  endfunction

  // Saturating scale to int16
  function automatic logic [15:0] to_int16(input logic signed [31:0] q);
    logic signed [48:0] p;
    logic signed [48:0] s;
    p = q * $signed({1'b0, `INT_FS});
    s = p >>> `FS_SHIFT;
    if ((&s[48:15]) || !(|s[48:15])) begin
      return s[15:0];
    end
    return s[48] ? 16'h8000 : 16'h7fff;
  endfunction

  // Index of the last byte of one sample
  function automatic logic [3:0] last_byte(input logic [1:0] ch, input logic fmt);
    logic [3:0] nb;
    nb = (ch == `CH_X) ? 4'h1 : ((ch == `CH_ALL) ? 4'h4 : 4'h2);
    nb = fmt ? 4'(nb << 1) : 4'(nb << 2);
    return nb - 4'h1;
  endfunction

  // Byte idx of a sample in wire order
  function automatic logic [7:0] pick_byte(input logic [3:0][31:0] w, input logic [1:0] ch,
                                          input logic fmt, input logic le, input logic [3:0] idx);
    logic [1:0] v;
    logic [1:0] b;
    v = fmt ? idx[2:1] : idx[3:2];
    b = fmt ? {1'b0, idx[0]} : idx[1:0];
    if (ch == `CH_RT) begin
      v = v + 2'h2;
    end
    if (!le) begin
      b = fmt ? {1'b0, ~b[0]} : ~b;
    end
    return w[v][8*b +: 8];
  endfunction

  // ----------------------------------------
  // State and wires
  // ----------------------------------------
  pack_s s_r;
  pack_s s_nxt;
  logic fifo_v;
  logic [8:0] fifo_d;
  logic fifo_rdy;
  logic [3:0][31:0] fv;
  logic [3:0][31:0] qv;

  assign fv = {t_f, r_f, y_f, x_f};
  assign qv = {t_q, r_q, y_q, x_q};

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    logic busy;
    logic tick;
    logic used;
    logic [20:0] maxr;
    busy = 1'b0;
    tick = 1'b0;
    used = 1'b0;
    maxr = '0;
    s_nxt = s_r;
    fifo_v = 1'b0;
    fifo_d = '0;
    busy = (s_r.ph != PH_IDLE) || (s_r.left != '0) || s_r.pend;

    // Register writes land in the shadow set
    if (reg_we) begin
      unique case (reg_addr)
        `REG_CHANNEL: s_nxt.ch = reg_wdata[1:0];
        `REG_RATE: s_nxt.rate = (reg_wdata > 32'(`RATE_EXP_MAX)) ?
                                `RATE_EXP_MAX : reg_wdata[4:0];
        `REG_FORMAT: s_nxt.fmt = reg_wdata[0];
        `REG_PACKET: s_nxt.pkt = reg_wdata[1:0];
        `REG_PORT: begin
          if (reg_wdata > `PORT_MAX) begin
            s_nxt.port = 16'(`PORT_MAX);
          end else if (reg_wdata[15:0] < `PORT_MIN) begin
            s_nxt.port = `PORT_MIN;
          end else begin
            s_nxt.port = reg_wdata[15:0];
          end
        end
        `REG_OPTIONS: s_nxt.opt = reg_wdata[1:0];
        `REG_ENABLE: begin
          if (reg_wdata[0]) begin
            if (!s_r.on) begin
              s_nxt.start = 1'b1;
              s_nxt.req_ip = cmd_src_ip;
            end
          end else begin
            s_nxt.on = 1'b0;
            s_nxt.start = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // Read data stands only in the cycle after the strobe
    // cap reported maximum
    maxr = (max_rate_hz > `RATE_CAP_HZ) ? `RATE_CAP_HZ : max_rate_hz;
    s_nxt.rdata = '0;
    if (reg_re) begin
      unique case (reg_addr)
        `REG_CHANNEL: s_nxt.rdata = {30'h0, s_r.ch};
        `REG_RATE: s_nxt.rdata = {27'h0, s_r.rate};
        `REG_FORMAT: s_nxt.rdata = {31'h0, s_r.fmt};
        `REG_PACKET: s_nxt.rdata = {30'h0, s_r.pkt};
        `REG_PORT: s_nxt.rdata = {16'h0, s_r.port};
        `REG_OPTIONS: s_nxt.rdata = {30'h0, s_r.opt};
        `REG_ENABLE: s_nxt.rdata = {31'h0, s_r.on};
        `REG_MAXRATE: s_nxt.rdata = {11'h0, maxr};
        `REG_STATUS: s_nxt.rdata = {s_r.drops, 14'h0, busy, s_r.on};
        default: s_nxt.rdata = '0;
      endcase
    end

    // settings latched at start
    // Start waits until a stopped stream has closed its packet
    if (s_r.start && !busy) begin
      s_nxt.start = 1'b0;
      s_nxt.on = 1'b1;
      s_nxt.a_ch = s_r.ch;
      s_nxt.a_rate = s_r.rate;
      s_nxt.a_fmt = s_r.fmt;
      s_nxt.a_pkt = s_r.pkt;
      s_nxt.a_opt = s_r.opt;
      s_nxt.dst_ip = s_r.req_ip;
      s_nxt.dst_port = s_r.port;
      s_nxt.div = '0;
      s_nxt.seq = '0;
      s_nxt.drops = '0;
    end

    // Framer: header, then whole samples up to packet end
    unique case (s_r.ph)
      PH_IDLE: begin
        if (s_r.pend) begin
          s_nxt.pend = 1'b0;
          if (s_r.on || (s_r.left != '0)) begin
            used = 1'b1;
            s_nxt.cur = s_r.cap;
            s_nxt.idx = '0;
            s_nxt.ph = (s_r.left == '0) ? PH_HDR : PH_DATA;
          end
        end
      end
      PH_HDR: begin
        fifo_v = 1'b1;
        unique case (s_r.idx[1:0])
          2'h0: fifo_d = {1'b0, s_r.a_opt[`OPT_CHECK] ? s_r.seq[15:8] : 8'h0};
          2'h1: fifo_d = {1'b0, s_r.a_opt[`OPT_CHECK] ? s_r.seq[7:0] : 8'h0};
          2'h2: fifo_d = {2'h0, s_r.a_opt, s_r.a_pkt, s_r.a_fmt, s_r.a_ch};
          2'h3: fifo_d = {1'b0, s_r.drops[7:0]};
        endcase
        if (fifo_rdy) begin
          if (s_r.idx == `HDR_LAST) begin
            s_nxt.ph = PH_DATA;
            s_nxt.idx = '0;
            s_nxt.left = `PKT_BASE >> s_r.a_pkt;
            s_nxt.seq = s_r.seq + 16'h1;
          end else begin
            s_nxt.idx = s_r.idx + 4'h1;
          end
        end
      end
      PH_DATA: begin
        fifo_v = 1'b1;
        fifo_d = {s_r.left == 11'h1,
                  pick_byte(s_r.cur, s_r.a_ch, s_r.a_fmt, s_r.a_opt[`OPT_LITTLE], s_r.idx)};
        if (fifo_rdy) begin
          // packet closes after header plus data
          s_nxt.left = s_r.left - 11'h1;
          if (s_r.idx == last_byte(s_r.a_ch, s_r.a_fmt)) begin
            s_nxt.ph = PH_IDLE;
            s_nxt.idx = '0;
          end else begin
            s_nxt.idx = s_r.idx + 4'h1;
          end
        end
      end
      default: s_nxt.ph = PH_IDLE;
    endcase

    // divide base rate by 2^n
    // A stopped stream keeps ticking only to fill its open packet
    if ((s_r.on || (s_r.left != '0)) && base_tick) begin
      if (s_r.div >= div_last(s_r.a_rate)) begin
        s_nxt.div = '0;
        tick = 1'b1;
      end else begin
        s_nxt.div = s_r.div + 20'h1;
      end
    end

    if (tick) begin
      if (s_r.pend && !used) begin
        s_nxt.drops = s_r.drops + 16'h1;
      end else begin
        s_nxt.pend = 1'b1;
        for (int i = 0; i < 4; i++) begin
          s_nxt.cap[i] = s_r.a_fmt ? {16'h0, to_int16(qv[i])} : fv[i];
        end
      end
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // reset defaults
  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
      s_r.port <= `PORT_DEF;
      s_r.opt <= `OPT_DEF;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // Output buffer toward the MAC
  // ----------------------------------------
  // A stalled MAC backs up into the framer, then drops samples
  sample_fifo #(
    .W(9),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(fifo_v),
    .in_data(fifo_d),
    .in_ready(fifo_rdy),
    .out_valid(tx_valid),
    .out_data({tx_last, tx_data}),
    .out_ready(tx_ready)
  );

  // Flop-driven status outputs
  assign reg_rdata = s_r.rdata;
  assign tx_dst_ip = s_r.dst_ip;
  assign tx_dst_port = s_r.dst_port;
  assign stream_active = s_r.on;
endmodule

// [hdl/packetizer_map.svh]
`ifndef PACKETIZER_MAP_SVH
`define PACKETIZER_MAP_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define REG_CHANNEL 8'h00
`define REG_RATE 8'h04
`define REG_FORMAT 8'h08
`define REG_PACKET 8'h0c
`define REG_PORT 8'h10
`define REG_OPTIONS 8'h14
`define REG_ENABLE 8'h18
`define REG_MAXRATE 8'h1c
`define REG_STATUS 8'h20

// ----------------------------------------
// Limits and reset values
// ----------------------------------------
`define RATE_EXP_MAX 5'h14
`define RATE_CAP_HZ 21'h1312d0
`define PORT_MIN 16'h0400
`define PORT_MAX 32'h0000ffff
`define PORT_DEF 16'h0749
`define OPT_DEF 2'h2

// ----------------------------------------
// Option bits and channel codes
// ----------------------------------------
`define OPT_LITTLE 0
`define OPT_CHECK 1
`define CH_X 2'h0
`define CH_RT 2'h2
`define CH_ALL 2'h3

// ----------------------------------------
// Framing and scaling
// ----------------------------------------
`define PKT_BASE 11'h400
`define HDR_LAST 4'h3
`define INT_FS 16'h7918
`define FS_SHIFT 30

`endif

// [hdl/packetizer_pkg.sv]
package packetizer_pkg;

  // ----------------------------------------
  // Framer phases
  // ----------------------------------------
  typedef enum logic [1:0] {PH_IDLE, PH_HDR, PH_DATA} phase_e;

  // ----------------------------------------
  // Whole state of the packetizer
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] ch;
    logic [4:0] rate;
    logic fmt;
    logic [1:0] pkt;
    logic [15:0] port;
    logic [1:0] opt;
    logic start;
    logic on;
    logic [31:0] req_ip;
    logic [1:0] a_ch;
    logic [4:0] a_rate;
    logic a_fmt;
    logic [1:0] a_pkt;
    logic [1:0] a_opt;
    logic [31:0] dst_ip;
    logic [15:0] dst_port;
    logic [31:0] rdata;
    logic [19:0] div;
    logic pend;
    logic [3:0][31:0] cap;
    logic [3:0][31:0] cur;
    phase_e ph;
    logic [3:0] idx;
    logic [10:0] left;
    logic [15:0] seq;
    logic [15:0] drops;
  } pack_s;

endpackage

// [dv/udp_sample_packetizer_props.sv]
`timescale 1ns/1ps
`include "packetizer_map.svh"

// ----------
// Port checker
// ----------
module pkt_props (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_re,
  input wire logic [31:0] reg_rdata,
  // Byte stream
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [31:0] tx_dst_ip,
  input wire logic [15:0] tx_dst_port,
  input wire logic stream_active
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  logic [10:0] cnt_r;
  logic [10:0] cnt_nxt;
  logic take;
  // Bytes taken since the last closing byte
  assign take = tx_valid && tx_ready;
  assign cnt_nxt = (take && tx_last) ? 11'h0 : cnt_r + 11'(take);
  always_ff @(posedge clk) begin
    cnt_r <= rst ? 11'h0 : cnt_nxt;
  end
  // Offered byte must wait for the host
  a_hold_byte: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_data) && $stable(tx_last)) else $error("byte lost before taken");
  a_pkt_len: assert property (take && tx_last |->
    cnt_r == 11'd131 || cnt_r == 11'd259 || cnt_r == 11'd515 || cnt_r == 11'd1027)
    else $error("datagram length wrong");
  a_rd_idle: assert property (!$past(reg_re) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  a_rate_read: assert property ($past(reg_re && reg_addr == `REG_RATE) |->
    reg_rdata <= 32'd20) else $error("rate exponent above limit");
  a_cap_read: assert property ($past(reg_re && reg_addr == `REG_MAXRATE) |->
    reg_rdata <= 32'd1250000) else $error("max rate above cap");
  a_fmt_read: assert property ($past(reg_re && reg_addr == `REG_FORMAT) |->
    reg_rdata[31:1] == 31'h0) else $error("format readback too wide");
  a_port_range: assert property (stream_active |-> tx_dst_port >= 16'h0400)
    else $error("port below range");
  a_dst_hold: assert property (stream_active && $past(stream_active) |->
    $stable(tx_dst_ip) && $stable(tx_dst_port)) else $error("destination moved in stream");
  c_start: cover property ($rose(stream_active));
  c_close: cover property (take && tx_last);
  c_stall: cover property (tx_valid && !tx_ready);
endmodule

bind udp_sample_packetizer pkt_props u_props (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_re(reg_re), .reg_rdata(reg_rdata),
  .tx_data(tx_data), .tx_last(tx_last), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .tx_dst_ip(tx_dst_ip), .tx_dst_port(tx_dst_port), .stream_active(stream_active)
);

// [dv/host_sink.sv]
`timescale 1ns/1ps

// ----------
// Receiving host
// ----------
module host_sink (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Byte stream
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic tx_valid,
  output logic tx_ready,
  // Bench control
  input wire logic slow
);
  logic [7:0] mem [0:4095];
  logic ph_r = 1'b0;
  int n = 0;
  int last_at = 0;
  int cyc = 0;
  int at_cyc [0:4095];
  // full-rate consumer
  // Slow mode takes every other cycle, to let the device fall behind
  assign tx_ready = !slow || ph_r;
  // Log each byte; a missed one is never asked for again
  always @(posedge clk) begin
    ph_r <= !ph_r;
    cyc <= cyc + 1;
    if (!rst && tx_valid && tx_ready) begin
      mem[n[11:0]] <= tx_data;
      at_cyc[n[11:0]] <= cyc;
      n <= n + 1;
      if (tx_last) begin
        last_at <= n;
      end
    end
  end
endmodule

// [dv/tb.sv]
`timescale 1ns/1ps
`include "packetizer_map.svh"

module tb;
  // ----------
  // Signals and cases
  // ----------
  typedef struct {
    logic we;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } row_s;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic [31:0] reg_rdata;
  logic [31:0] cmd_src_ip = 32'h0a000001;
  logic base_tick = 1'b0;
  logic [20:0] max_rate_hz = 21'h1fffff;
  logic [31:0] x_f = 32'h0, y_f = 32'h0, r_f = 32'h0, t_f = 32'h0;
  logic signed [31:0] x_q = 32'h40000000, y_q = 32'h80000000;
  logic signed [31:0] r_q = 32'h0, t_q = 32'h20000000;
  logic [7:0] tx_data;
  logic [31:0] tx_dst_ip;
  logic [15:0] tx_dst_port;
  logic tx_last, tx_valid, tx_ready, stream_active;
  logic slow = 1'b0;
  logic [31:0] v;
  int n_mismatch = 0;
  int tests_run = 0;
  int tper = 16;
  int tcnt = 0;
  int base = 0;
  int k;
  logic [7:0] pat [8] = '{8'h79, 8'h18, 8'h80, 8'h00, 8'h00, 8'h00, 8'h3c, 8'h8c};
  logic [7:0] fpat [4] = '{8'h00, 8'h00, 8'h80, 8'h3f};
  row_s rows [12] = '{'{1'b1, `REG_CHANNEL, 32'h3, 32'h3}, '{1'b0, `REG_ENABLE, 32'h0, 32'h0},
    '{1'b1, `REG_RATE, 32'h19, 32'h14}, '{1'b1, `REG_RATE, 32'h7, 32'h7},
    '{1'b1, `REG_FORMAT, 32'h1, 32'h1}, '{1'b1, `REG_PACKET, 32'h2, 32'h2},
    '{1'b1, `REG_PORT, 32'h3ff, 32'h400}, '{1'b1, `REG_PORT, 32'h10000, 32'hffff},
    '{1'b1, `REG_PORT, 32'h3039, 32'h3039}, '{1'b1, `REG_OPTIONS, 32'h3, 32'h3},
    '{1'b1, 8'h40, 32'h5, 32'h0}, '{1'b1, `REG_MAXRATE, 32'h0, 32'h1312d0}};

  udp_sample_packetizer #(.FIFO_DEPTH(8)) dut (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re), .reg_rdata(reg_rdata), .cmd_src_ip(cmd_src_ip), .base_tick(base_tick),
    .max_rate_hz(max_rate_hz), .x_f(x_f), .y_f(y_f), .r_f(r_f), .t_f(t_f), .x_q(x_q),
    .y_q(y_q), .r_q(r_q), .t_q(t_q), .tx_data(tx_data), .tx_last(tx_last),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_dst_ip(tx_dst_ip),
    .tx_dst_port(tx_dst_port), .stream_active(stream_active));
  host_sink u_host (.clk(clk), .rst(rst), .tx_data(tx_data), .tx_last(tx_last),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .slow(slow));

  // ----------
  // Clock, tick source, tasks
  // ----------
  initial begin
    forever #2.5 clk = ~clk;
  end
  // Tick spacing set per scenario
  always @(posedge clk) begin
    tcnt <= (tcnt + 1 >= tper) ? 0 : tcnt + 1;
    base_tick <= (tcnt == 0);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    @(posedge clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    #1 q = reg_rdata;
  endtask
  task automatic chb(input int i, input logic [7:0] e);
    chk({24'h0, u_host.mem[base + i]}, {24'h0, e});
  endtask
  function automatic logic [31:0] w4(input int i);
    return {u_host.mem[base + i], u_host.mem[base + i + 1], u_host.mem[base + i + 2],
      u_host.mem[base + i + 3]};
  endfunction
  // Stop, then wait for the open packet to drain
  task automatic stop_wait();
    wr(`REG_ENABLE, 32'h0);
    for (int i = 0; i < 300; i++) begin
      rd(`REG_STATUS, v);
      if (v[1:0] == 2'b00) break;
    end
    repeat (20) @(posedge clk);
    chk({30'h0, v[1:0]}, 32'h0);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------
  // Main sequence
  // ----------
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].we) wr(rows[i].a, rows[i].d);
      rd(rows[i].a, v);
      chk(v, rows[i].e);
    end
    // Reported maximum follows the filter below the cap
    @(posedge clk);
    max_rate_hz <= 21'h01312d;
    rd(`REG_MAXRATE, v);
    chk(v, 32'h0001312d);
    // Second reset restores defaults
    @(posedge clk);
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(`REG_PORT, v);
    chk(v, 32'h749);
    rd(`REG_OPTIONS, v);
    chk(v, 32'h2);
    // Four values, int16, big-endian, 128-byte packets
    wr(`REG_CHANNEL, 32'h3);
    wr(`REG_FORMAT, 32'h1);
    wr(`REG_PACKET, 32'h3);
    wr(`REG_PORT, 32'h3039);
    base = u_host.n;
    wr(`REG_ENABLE, 32'h1);
    for (k = 0; k < 20 && !stream_active; k++) @(posedge clk);
    chk({31'h0, stream_active}, 32'h1);
    chk(tx_dst_ip, 32'h0a000001);
    chk({16'h0, tx_dst_port}, 32'h3039);
    // Shadow change must wait for the next start
    wr(`REG_CHANNEL, 32'h0);
    for (k = 0; k < 3000 && u_host.n < base + 264; k++) @(posedge clk);
    chk(w4(0), 32'h00005f00);
    chk(w4(132), 32'h00015f00);
    chk(32'(u_host.last_at - base), 32'd263);
    for (k = 0; k < 128; k++) chb(4 + k, pat[k % 8]);
    // Stop closes the open packet first
    stop_wait();
    chk(32'((u_host.n - base) % 132), 32'h0);
    // X only, float32 little-endian, ticks too fast for a slow host
    wr(`REG_FORMAT, 32'h0);
    wr(`REG_OPTIONS, 32'h1);
    wr(`REG_RATE, 32'h1);
    x_f <= 32'h3f800000;
    tper = 1;
    slow <= 1'b1;
    base = u_host.n;
    wr(`REG_ENABLE, 32'h1);
    for (k = 0; k < 3000 && u_host.n < base + 132; k++) @(posedge clk);
    chk(w4(0) & 32'hffffff00, 32'h00003800);
    for (k = 0; k < 128; k++) chb(4 + k, fpat[k % 4]);
    rd(`REG_STATUS, v);
    chk({31'h0, v[0]}, 32'h1);
    chk({31'h0, v[31:16] != 16'h0}, 32'h1);
    // R and theta, int16, big-endian, 256-byte packets, steady 16-cycle samples
    slow <= 1'b0;
    stop_wait();
    chk(32'((u_host.n - base) % 132), 32'h0);
    wr(`REG_CHANNEL, 32'h2);
    wr(`REG_FORMAT, 32'h1);
    wr(`REG_OPTIONS, 32'h0);
    wr(`REG_PACKET, 32'h2);
    wr(`REG_RATE, 32'h2);
    tper = 4;
    base = u_host.n;
    wr(`REG_ENABLE, 32'h1);
    for (k = 0; k < 3000 && u_host.n < base + 260; k++) @(posedge clk);
    chk(w4(0), 32'h00001600);
    chk(32'(u_host.last_at - base), 32'd259);
    for (k = 0; k < 256; k++) chb(4 + k, pat[4 + k % 4]);
    // Sample 1 to sample 63: 62 gaps of 4 ticks of 4 cycles
    chk(32'(u_host.at_cyc[base + 256] - u_host.at_cyc[base + 8]), 32'd992);
    summarize();
  end

  // Hang guard, well past the expected run
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    summarize();
  end
endmodule
